// [sscl_checker.sv]
// checker of bus wait state, load pulse and latched configuration
// assumes bind onto sscl_loader
`timescale 1ns/1ns
module sscl_checker (
  // bus
  input wire logic        i_core_clk,
  input wire logic        i_sys_rst,
  input wire logic [4:0]  i_avs_address,
  input wire logic        i_avs_read,
  input wire logic        i_avs_write,
  input wire logic [15:0] i_avs_writedata,
  input wire logic [15:0] o_avs_readdata,
  input wire logic        o_avs_waitrequest,
  // configuration
  input wire logic        o_internal_rst,
  input wire logic        o_cfg_ready,
  input wire logic        o_xover_en,
  input wire logic [1:0]  o_lamp_alt_sel,
  input wire logic [15:0] o_basic_ctrl,
  input wire logic [15:0] o_advertise
);
  default clocking @(posedge i_core_clk); endclocking
  default disable iff (i_sys_rst);
  wire       rq = i_avs_read | i_avs_write;
  wire       rd = i_avs_read & ~o_avs_waitrequest;
  wire       wt = i_avs_write & ~o_avs_waitrequest;
  wire [4:0] a  = i_avs_address;
  wire [1:0] ws = i_avs_writedata[6:5];
  a_wait_first: assert property (rq && !$past(rq) |-> o_avs_waitrequest)
    else $error("no wait state");
  a_wait_one: assert property (rq && o_avs_waitrequest ##1 rq |-> !o_avs_waitrequest)
    else $error("long wait");
  // a done repeated during the pulse must not restart it
  a_pulse_len: assert property (wt && a == 5'h09 && i_avs_writedata[15]
    && !o_internal_rst && !o_cfg_ready |=> o_internal_rst [*5] ##1 (!o_internal_rst && o_cfg_ready))
    else $error("bad pulse");
  a_ready_hold: assert property (o_cfg_ready |=> o_cfg_ready)
    else $error("ready dropped");
  a_pulse_excl: assert property (o_internal_rst |-> !o_cfg_ready)
    else $error("ready in pulse");
  a_cfg_frozen: assert property (o_cfg_ready |-> $stable(o_xover_en)
    && $stable(o_basic_ctrl) && $stable(o_advertise)) else $error("config moved");
  a_image_read: assert property (rd && o_cfg_ready && (a == 5'h00 || a == 5'h04)
    |-> o_avs_readdata == (a == 5'h00 ? o_basic_ctrl : o_advertise)) else $error("image");
  a_xover_mirror: assert property (rd && a == 5'h09 && o_cfg_ready
    |-> o_avs_readdata[14] == o_xover_en) else $error("crossover");
  a_lamp_sel: assert property (wt && a == 5'h18 |=> o_lamp_alt_sel == $past(ws))
    else $error("lamp select");
endmodule
bind sscl_loader sscl_checker sscl_checker_i (
  .i_core_clk, .i_sys_rst, .i_avs_address, .i_avs_read, .i_avs_write,
  .i_avs_writedata, .o_avs_readdata, .o_avs_waitrequest, .o_internal_rst,
  .o_cfg_ready, .o_xover_en, .o_lamp_alt_sel, .o_basic_ctrl, .o_advertise
);

// [sscl_decode.sv]
// decoder of negotiation enable plus mode pair into control/advertise bits
// assumes pure combinational use by the loader top
`timescale 1ns/1ns
`include "sscl_params.svh"
module sscl_decode
  import sscl_pkg::*;
(
  // strap fields
  input  wire logic        i_neg_en,
  input  wire logic [1:0]  i_mode_pair,
  // decoded register images
  output logic      [15:0] o_basic_ctrl,
  output logic      [15:0] o_advertise
);
  always_comb begin
    o_basic_ctrl = `SSCL_RST_BASIC_CTRL;
    o_advertise  = `SSCL_RST_ADVERTISE;
    o_basic_ctrl[`SSCL_BIT_BC_NEG] = i_neg_en;
    if (!i_neg_en) begin
      // forced: high bit picks speed, low bit picks duplex
      o_basic_ctrl[`SSCL_BIT_BC_SPEED]  = i_mode_pair[1];
      o_basic_ctrl[`SSCL_BIT_BC_DUPLEX] = i_mode_pair[0];
      o_advertise[`SSCL_BIT_AD_10H]  = ~i_mode_pair[1] & ~i_mode_pair[0];
      o_advertise[`SSCL_BIT_AD_10F]  = ~i_mode_pair[1] & i_mode_pair[0];
      o_advertise[`SSCL_BIT_AD_100H] = i_mode_pair[1] & ~i_mode_pair[0];
      o_advertise[`SSCL_BIT_AD_100F] = i_mode_pair[1] & i_mode_pair[0];
    end else begin
      unique case (i_mode_pair)
        2'h0: begin
          o_advertise[`SSCL_BIT_AD_10H] = 1'b1;
          o_advertise[`SSCL_BIT_AD_10F] = 1'b1;
        end
        2'h1: begin
          o_advertise[`SSCL_BIT_AD_100H] = 1'b1;
          o_advertise[`SSCL_BIT_AD_100F] = 1'b1;
        end
        2'h2: begin
          o_advertise[`SSCL_BIT_AD_10H]  = 1'b1;
          o_advertise[`SSCL_BIT_AD_100H] = 1'b1;
        end
        2'h3: begin
          o_advertise[`SSCL_BIT_AD_10H]  = 1'b1;
          o_advertise[`SSCL_BIT_AD_10F]  = 1'b1;
          o_advertise[`SSCL_BIT_AD_100H] = 1'b1;
          o_advertise[`SSCL_BIT_AD_100F] = 1'b1;
        end
      endcase
      // negotiation forces full speed/duplex bits low in the control image
      o_basic_ctrl[`SSCL_BIT_BC_SPEED]  = 1'b0;
      o_basic_ctrl[`SSCL_BIT_BC_DUPLEX] = 1'b0;
    end
  end
endmodule

// [sscl_host.sv]
// processor model: avalon-mm master making single accesses
// assumes xfer is called once the previous access has ended
`timescale 1ns/1ns
module sscl_host (
  // clock and answer
  input  wire logic        i_core_clk,
  input  wire logic        i_waitrequest,
  // request
  output logic             o_read      = 1'b0,
  output logic             o_write     = 1'b0,
  output logic [4:0]       o_address   = 5'h00,
  output logic [15:0]      o_writedata = 16'h0000,
  output logic             o_hung      = 1'b0
);
  // straps reach the device through its pins after reset and through register writes
  task automatic xfer(input logic w, input logic [4:0] a, input logic [15:0] d);
    int n;
    @(posedge i_core_clk);
    o_read      <= ~w;
    o_write     <= w;
    o_address   <= a;
    o_writedata <= d;
    n = 0;
    // waitrequest is sampled on the rising edge; the access ends at that edge
    @(posedge i_core_clk);
    while (i_waitrequest !== 1'b0 && n < 40) begin
      @(posedge i_core_clk);
      n++;
    end
    o_hung = (n >= 40);
    o_read      <= 1'b0;
    o_write     <= 1'b0;
    // released lines invert so stale values cannot pass
    o_address   <= ~a;
    o_writedata <= ~d;
  endtask
endmodule

// [sscl_loader.sv]
// soft strap loader: strap register, completion handshake, latched configuration
// assumes an Avalon-MM master on i_core_clk; strap pins are asynchronous
`timescale 1ns/1ns
`include "sscl_params.svh"
module sscl_loader
  import sscl_pkg::*;
(
  // clock and reset
  input  wire logic        i_core_clk,
  input  wire logic        i_sys_rst,
  // avalon-mm slave, word addressed by register index
  input  wire logic [4:0]  i_avs_address,
  input  wire logic        i_avs_read,
  input  wire logic        i_avs_write,
  input  wire logic [15:0] i_avs_writedata,
  output logic      [15:0] o_avs_readdata,
  output logic             o_avs_waitrequest,
  // strap pins and their use flags
  input  wire logic        i_strap_xover,
  input  wire logic        i_strap_neg,
  input  wire logic [1:0]  i_strap_mode,
  input  wire logic        i_strap_lamp,
  input  wire logic [3:0]  i_strap_pin_used,
  // latched configuration
  output logic             o_internal_rst,
  output logic             o_cfg_ready,
  output logic             o_xover_en,
  output logic             o_lamp_scheme_one,
  output logic [1:0]       o_lamp_alt_sel,
  output logic [15:0]      o_basic_ctrl,
  output logic [15:0]      o_advertise
);
  localparam logic [3:0] PULSE_LAST = 4'(`SSCL_PULSE_CYC - 1);

  logic [5:0]  pin_meta_r;
  logic [5:0]  pin_sync_r;
  logic [3:0]  used_meta_r;
  logic [3:0]  used_sync_r;
  logic        sampled_r;
  logic [15:0] strap_r;
  logic [15:0] lamp_ctrl_r;
  logic [15:0] bc_r;
  logic [15:0] ad_r;
  logic        xover_r;
  logic        lamp_r;
  logic [3:0]  pulse_cnt_r;
  logic        ack_r;
  sscl_state_t state_r;
  logic [15:0] dec_bc;
  logic [15:0] dec_ad;
  logic        wr_hit;
  logic        done_wr;

  // pins cross two flops before use
  always_ff @(posedge i_core_clk) begin
    pin_meta_r  <= {i_strap_xover, i_strap_neg, i_strap_mode, i_strap_lamp, 1'b0};
    pin_sync_r  <= pin_meta_r;
    used_meta_r <= i_strap_pin_used;
    used_sync_r <= used_meta_r;
  end

  // one wait state per access: waitrequest high on the first request cycle
  always_ff @(posedge i_core_clk) begin
    if (i_sys_rst) begin
      ack_r <= 1'b0;
    end else begin
      ack_r <= (i_avs_read | i_avs_write) & ~ack_r;
    end
  end
  assign o_avs_waitrequest = (i_avs_read | i_avs_write) & ~ack_r;
  assign wr_hit  = i_avs_write & ack_r;
  // straps frozen once done
  assign done_wr = wr_hit && (i_avs_address == `SSCL_IDX_STRAP_CTRL)
                   && state_r == SSCL_WAIT_CFG && i_avs_writedata[`SSCL_BIT_DONE];

  // strap register; pin level becomes the default after reset
  always_ff @(posedge i_core_clk) begin
    if (i_sys_rst) begin
      strap_r   <= 16'h0000;
      strap_r[`SSCL_BIT_XOVER]   <= 1'b1;
      strap_r[`SSCL_BIT_NEG]     <= 1'b1;
      strap_r[`SSCL_BIT_MODE_HI] <= 1'b1;
      strap_r[`SSCL_BIT_MODE_LO] <= 1'b1;
      strap_r[`SSCL_BIT_LAMP]    <= 1'b1;
      sampled_r <= 1'b0;
    end else if (!sampled_r) begin
      sampled_r <= 1'b1;
      if (used_sync_r[0]) strap_r[`SSCL_BIT_XOVER] <= pin_sync_r[5];
      if (used_sync_r[1]) strap_r[`SSCL_BIT_NEG] <= pin_sync_r[4];
      if (used_sync_r[2]) begin
        strap_r[`SSCL_BIT_MODE_HI] <= pin_sync_r[3];
        strap_r[`SSCL_BIT_MODE_LO] <= pin_sync_r[2];
      end
      if (used_sync_r[3]) strap_r[`SSCL_BIT_LAMP] <= pin_sync_r[1];
    end else if (wr_hit && i_avs_address == `SSCL_IDX_STRAP_CTRL
                 && state_r == SSCL_WAIT_CFG) begin
      // values and done land together; software orders them
      strap_r[14:10] <= i_avs_writedata[14:10];
      strap_r[`SSCL_BIT_DONE] <= i_avs_writedata[`SSCL_BIT_DONE];
    end
  end

  // lamp control stays writable; only bits 6:5 steer the alternate scheme
  always_ff @(posedge i_core_clk) begin
    if (i_sys_rst) begin
      lamp_ctrl_r <= `SSCL_RST_LAMP_CTRL;
    end else if (wr_hit && i_avs_address == `SSCL_IDX_LAMP_CTRL) begin
      lamp_ctrl_r <= i_avs_writedata;
    end
  end

  // completion sequence; and
  always_ff @(posedge i_core_clk) begin
    if (i_sys_rst) begin
      state_r     <= SSCL_WAIT_CFG;
      pulse_cnt_r <= 4'h0;
    end else begin
      unique case (state_r)
        SSCL_WAIT_CFG: begin
          pulse_cnt_r <= 4'h0;
          if (done_wr && sampled_r) begin
            state_r <= SSCL_PULSE;
          end
        end
        SSCL_PULSE: begin
          pulse_cnt_r <= pulse_cnt_r + 4'h1;
          if (pulse_cnt_r == PULSE_LAST) begin
            state_r <= SSCL_RUN;
          end
        end
        SSCL_RUN: begin
          pulse_cnt_r <= 4'h0;
        end
        default: begin
          state_r <= SSCL_WAIT_CFG;
        end
      endcase
    end
  end

  sscl_decode u_decode (
    .i_neg_en    (strap_r[`SSCL_BIT_NEG]),
    .i_mode_pair (strap_r[`SSCL_BIT_MODE_HI:`SSCL_BIT_MODE_LO]),
    .o_basic_ctrl(dec_bc),
    .o_advertise (dec_ad)
  );

  // capture at the first pulse cycle, so latched values match the strap image
  always_ff @(posedge i_core_clk) begin
    if (i_sys_rst) begin
      bc_r    <= `SSCL_RST_BASIC_CTRL;
      ad_r    <= `SSCL_RST_ADVERTISE;
      xover_r <= 1'b1;
      lamp_r  <= 1'b1;
    end else if (state_r == SSCL_PULSE && pulse_cnt_r == 4'h0) begin
      bc_r    <= dec_bc;
      ad_r    <= dec_ad;
      xover_r <= strap_r[`SSCL_BIT_XOVER];
      lamp_r  <= strap_r[`SSCL_BIT_LAMP];
    end
  end

  // read data registered on the edge ending the wait-state cycle; unmapped reads give zero
  always_ff @(posedge i_core_clk) begin
    if (i_sys_rst) begin
      o_avs_readdata <= 16'h0000;
    end else if (i_avs_read && !ack_r) begin
      unique case (i_avs_address)
        `SSCL_IDX_BASIC_CTRL:  o_avs_readdata <= bc_r;
        `SSCL_IDX_ADVERTISE:   o_avs_readdata <= ad_r;
        `SSCL_IDX_STRAP_CTRL:  o_avs_readdata <= strap_r;
        `SSCL_IDX_LAMP_CTRL:   o_avs_readdata <= lamp_ctrl_r;
        `SSCL_IDX_LOADER_STAT: o_avs_readdata <= {14'h0000, state_r};
        default:               o_avs_readdata <= 16'h0000;
      endcase
    end
  end

  assign o_internal_rst    = (state_r == SSCL_PULSE);
  assign o_cfg_ready       = (state_r == SSCL_RUN);
  assign o_xover_en        = xover_r;
  assign o_lamp_scheme_one = lamp_r;
  assign o_lamp_alt_sel    = lamp_ctrl_r[`SSCL_BIT_LAMP_SEL_HI:`SSCL_BIT_LAMP_SEL_LO];
  assign o_basic_ctrl      = bc_r;
  assign o_advertise       = ad_r;
endmodule

// [sscl_loader_tb.sv]
// bench: eight strap setups, each reset, loaded and read back
// assumes sscl_host drives the bus and the bound checker watches timing
`timescale 1ns/1ns
module sscl_loader_tb;
  logic        clk, rst, px, pn, pl, rd, wr, wq, hung, irst, rdy, xo, l1;
  logic [1:0]  pm, alt, sel;
  logic [3:0]  used;
  logic [4:0]  adr;
  logic [15:0] wd, rdat, bc, ad, v, e;
  logic [15:0] q[$];
  int          fails, samples_checked;
  sscl_loader sscl_loader_i (.i_core_clk(clk), .i_sys_rst(rst), .i_avs_address(adr),
    .i_avs_read(rd), .i_avs_write(wr), .i_avs_writedata(wd), .o_avs_readdata(rdat),
    .o_avs_waitrequest(wq), .i_strap_xover(px), .i_strap_neg(pn), .i_strap_mode(pm),
    .i_strap_lamp(pl), .i_strap_pin_used(used), .o_internal_rst(irst), .o_cfg_ready(rdy),
    .o_xover_en(xo), .o_lamp_scheme_one(l1), .o_lamp_alt_sel(sel), .o_basic_ctrl(bc),
    .o_advertise(ad));
  sscl_host sscl_host_i (.i_core_clk(clk), .i_waitrequest(wq), .o_read(rd), .o_write(wr),
    .o_address(adr), .o_writedata(wd), .o_hung(hung));
  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end
  task chk(input logic [15:0] g, input logic [15:0] x);
    samples_checked++;
    if (g !== x) begin
      fails++;
      $display("unexpected at %0t: got %h want %h", $time, g, x);
    end
  endtask
  task finish_test;
    $display("checked %0d failed %0d", samples_checked, fails);
    if (fails == 0 && samples_checked > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  // a read notes its expected word; the watcher below compares it
  task acc(input logic w, input logic [4:0] a, input logic [15:0] d);
    if (!w) q.push_back(d);
    sscl_host_i.xfer(w, a, w ? d : 16'h0000);
    if (hung) begin
      fails++;
      finish_test;
    end
  endtask
  always @(posedge clk) if (rd && wq === 1'b0) chk(rdat, q.pop_front());
  function automatic logic [15:0] adv(input logic n, input logic [1:0] m);
    case ({n, m})
      3'b100:  adv = 16'h0061;
      3'b101:  adv = 16'h0181;
      3'b110:  adv = 16'h00a1;
      3'b111:  adv = 16'h01e1;
      default: adv = 16'h0001 | (16'h0020 << m);
    endcase
  endfunction
  initial begin
    {rst, px, pn, pm, pl, used, alt, v} = {1'b1, 27'h0};
    fails = 0;
    samples_checked = 0;
    void'($urandom(49415));
    repeat (12) @(posedge clk);
    for (int i = 0; i < 8; i++) begin
      rst <= 1'b1;
      {px, pn, pm, pl, used, alt} <= 11'($urandom);
      v <= {1'b0, 1'($urandom), i[2], i[1:0], 1'($urandom), 10'h000};
      repeat (4) @(posedge clk);
      rst <= 1'b0;
      repeat (3) @(posedge clk);
      e = {1'b0, used[0] ? px : 1'b1, used[1] ? pn : 1'b1, used[2] ? pm : 2'b11,
           used[3] ? pl : 1'b1, 10'h000};
      acc(1'b0, 5'h09, e);
      acc(1'b1, 5'h09, v);
      acc(1'b0, 5'h09, v);
      acc(1'b1, 5'h18, {9'h000, alt, 5'h00});
      acc(1'b1, 5'h09, v | 16'h8000);
      acc(1'b1, 5'h09, 16'h0000);
      acc(1'b0, 5'h09, v | 16'h8000);
      for (int n = 0; n < 40 && rdy !== 1'b1; n++) @(posedge clk);
      chk(rdy, 1'b1);
      chk(xo, v[14]);
      chk(l1, v[10]);
      chk(sel, alt);
      chk(bc & (v[13] ? 16'h1000 : 16'h3100),
          v[13] ? 16'h1000 : {2'b00, v[12], 4'h0, v[11], 8'h00});
      chk(ad, adv(v[13], v[12:11]));
      acc(1'b0, 5'h04, adv(v[13], v[12:11]));
      acc(1'b0, 5'h05, 16'h0000);
      acc(1'b0, 5'h1f, 16'h0002);
      $display("setup %0d done", i);
    end
    finish_test;
  end
endmodule

// [sscl_params.svh]
// soft strap loader constants: offsets, field positions, resets, timing
// assumes inclusion by the decoder and loader modules; definitions only
// How it works
// - done bit fires internal reset, captures straps
// - bit 14 enables crossover, default one
// - negotiation on: mode bits pick advertised abilities
// - decode three bits into control and advertise
// - bit 10 lamp scheme one, else lamp register
// - strap pin level loaded as bit default
`ifndef SSCL_PARAMS_SVH
`define SSCL_PARAMS_SVH
`define SSCL_IDX_BASIC_CTRL   5'h00
`define SSCL_IDX_ADVERTISE    5'h04
`define SSCL_IDX_STRAP_CTRL   5'h09
`define SSCL_IDX_LAMP_CTRL    5'h18
`define SSCL_IDX_LOADER_STAT  5'h1f
`define SSCL_BIT_DONE         15
`define SSCL_BIT_XOVER        14
`define SSCL_BIT_NEG          13
`define SSCL_BIT_MODE_HI      12
`define SSCL_BIT_MODE_LO      11
`define SSCL_BIT_LAMP         10
`define SSCL_BIT_LAMP_SEL_LO  5
`define SSCL_BIT_LAMP_SEL_HI  6
`define SSCL_BIT_BC_NEG       12
`define SSCL_BIT_BC_SPEED     13
`define SSCL_BIT_BC_DUPLEX    8
`define SSCL_BIT_AD_10H       5
`define SSCL_BIT_AD_10F       6
`define SSCL_BIT_AD_100H      7
`define SSCL_BIT_AD_100F      8
`define SSCL_RST_BASIC_CTRL   16'h0000
`define SSCL_RST_ADVERTISE    16'h0001
`define SSCL_RST_LAMP_CTRL    16'h0000
`define SSCL_PULSE_NS         100
`define SSCL_CLK_NS           20
`define SSCL_PULSE_CYC        ((`SSCL_PULSE_NS + `SSCL_CLK_NS - 1) / `SSCL_CLK_NS)
`endif

// [sscl_pkg.sv]
// soft strap loader types
// assumes sscl_params.svh is on the include path
package sscl_pkg;
  typedef enum logic [1:0] {
    SSCL_WAIT_CFG = 2'b00,
    SSCL_PULSE    = 2'b01,
    SSCL_RUN      = 2'b10
  } sscl_state_t;
endpackage
